// ### logic/sac_defs.vh
`ifndef SAC_DEFS_VH
`define SAC_DEFS_VH

// register word offsets on the bus, matched against address bits 7:2
`define SAC_OFS_CTRL      6'h00
`define SAC_OFS_CFG       6'h01
`define SAC_OFS_POS       6'h02
`define SAC_OFS_NEG       6'h03
`define SAC_OFS_RES_HI    6'h04
`define SAC_OFS_RES_LO    6'h05

// reset values
`define SAC_RST_CTRL      8'h00
`define SAC_RST_CFG       8'hf8
`define SAC_RST_POS       5'h1f
`define SAC_RST_NEG       5'h1f

// control register fields
`define SAC_CTRL_EN       7
`define SAC_CTRL_TM       6
`define SAC_CTRL_DONE     5
`define SAC_CTRL_BUSY     4

// configuration register fields
`define SAC_CFG_DIV_HI    7
`define SAC_CFG_DIV_LO    3
`define SAC_CFG_LJST      2

// start-source codes
`define SAC_SRC_SW        3'h0
`define SAC_SRC_T0        3'h1
`define SAC_SRC_T2        3'h2
`define SAC_SRC_T1        3'h3
`define SAC_SRC_PIN       3'h4
`define SAC_SRC_T3        3'h5

// negative-input code for ground (single-ended mode)
`define SAC_NEG_GND       5'h11

// timing and widths
`define SAC_TRACK_CLKS    2'h3
`define SAC_RES_BITS      10

`endif

// ### logic/sac_sar_core.v
`timescale 1ns/10ps
`include "sac_defs.vh"

// successive-approximation step engine, one bit per sar clock tick
module sac_sar_core #(
  parameter NBITS = `SAC_RES_BITS
) (
  input  wire             hclk,
  input  wire             hresetn,
  input  wire             tick,
  input  wire             start,
  input  wire             cmp_ge,
  output reg  [NBITS-1:0] trial_q,
  output reg  [NBITS-1:0] result_q,
  output reg              busy_q,
  output reg              done_q
);

  reg [NBITS-1:0] mask_q;

  // one trial bit decided per tick, msb first
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trial_q  <= {NBITS{1'b0}};
      result_q <= {NBITS{1'b0}};
      mask_q   <= {NBITS{1'b0}};
      busy_q   <= 1'b0;
      done_q   <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (start && !busy_q) begin
        trial_q <= {1'b1, {(NBITS-1){1'b0}}};
        mask_q  <= {1'b1, {(NBITS-1){1'b0}}};
        busy_q  <= 1'b1;
      end else if (busy_q && tick) begin // [RULE28]
        mask_q <= mask_q >> 1;
        if (mask_q[0]) begin
          result_q <= cmp_ge ? trial_q : (trial_q & ~mask_q);
          busy_q   <= 1'b0;
          done_q   <= 1'b1;
        end else begin
          trial_q <= (cmp_ge ? trial_q : (trial_q & ~mask_q))
                     | (mask_q >> 1);
        end
      end
    end
  end

endmodule // sac_sar_core

// ### logic/sac_top.v
// Summary of operation
// [RULE1] converter runs only while enable bit set
// [RULE2] mux routes one positive, one negative source
// [RULE3] ground negative means single-ended, else differential
// [RULE4] single-ended result is 10-bit unsigned
// [RULE5] single-ended unused result bits read zero
// [RULE6] differential result is 10-bit two's complement
// [RULE7] right-justified differential sign-extends high byte
// [RULE8] left-justified differential low bits read zero
// [RULE9] result loaded at completion, justified per setting
// [RULE10] sar clock is system clock over divider+1
// [RULE11] start source selects one of six triggers
// [RULE12] software mode: writing busy one starts
// [RULE13] busy reads one throughout each conversion
// [RULE14] busy falling edge sets done flag, interrupt
// [RULE15] result valid whenever done flag reads one
// [RULE16] software polls done flag, not busy
// [RULE17] timer 2/3 use low or high overflow
// [RULE18] pin mode starts on external rising edge
// [RULE19] normal track mode tracks except converting
// [RULE20] low-power mode tracks three sar clocks first
// [RULE21] low-power pin mode tracks while pin low
// [RULE22] tracking shuts down in standby or sleep
// [RULE23] start-source codes fixed, 11x reserved
// [RULE24] justify bit zero right, one left
// [RULE25] negative code 10001 ground, above none
// [RULE26] done flag stays set until software clears
// [RULE27] triggers ignored while conversion under way
// [RULE28] fixed steps per result bit after tracking
//
// Chosen here: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/10ps
`include "sac_defs.vh"

module sac_top #(
  parameter NBITS = `SAC_RES_BITS
) (
  input  wire             hclk,
  input  wire             hresetn,
  input  wire             hsel,
  input  wire [31:0]      haddr,
  input  wire [1:0]       htrans,
  input  wire             hwrite,
  input  wire [2:0]       hsize,
  input  wire [31:0]      hwdata,
  input  wire             hready,
  output reg              hreadyout,
  output reg  [31:0]      hrdata,
  output reg              hresp,
  input  wire             timer0_ovf,
  input  wire             timer1_ovf,
  input  wire             timer2_lo_ovf,
  input  wire             timer2_hi_ovf,
  input  wire             timer2_split,
  input  wire             timer3_lo_ovf,
  input  wire             timer3_hi_ovf,
  input  wire             timer3_split,
  input  wire             external_convert_start,
  input  wire             comparator_in,
  input  wire             low_power_standby,
  input  wire             irq_enable,
  output reg              converter_power_q,
  output reg              track_en_q,
  output reg  [4:0]       pos_mux_sel_q,
  output reg  [4:0]       neg_mux_sel_q,
  output reg              diff_mode_q,
  output wire [NBITS-1:0] sar_trial_q,
  output reg              conv_irq_q
);

  localparam ST_IDLE  = 2'h0;
  localparam ST_TRACK = 2'h1;
  localparam ST_CONV  = 2'h2;

  // configuration reset word, split into its fields below
  localparam [7:0] RST_CFG = `SAC_RST_CFG;

  // software-visible control state
  reg        converter_enable_bit_q;
  reg        track_mode_select_q;
  reg        conversion_done_flag_q;
  reg [2:0]  start_source_select_q;
  reg [4:0]  sar_clock_divider_q;
  reg        justify_select_q;
  reg [7:0]  result_high_byte_q;
  reg [7:0]  result_low_byte_q;

  // bus data-phase state
  reg        wr_pend_q;
  reg [5:0]  wr_idx_q;

  // conversion state
  reg [1:0]  state_q;
  reg [1:0]  state_d;
  reg [1:0]  track_cnt_q;
  reg [4:0]  div_cnt_q;
  reg        sar_tick_q;
  reg        pin_meta_q;
  reg        pin_sync_q;
  reg        pin_prev_q;
  reg        cmp_meta_q;
  reg        cmp_sync_q;
  reg        sw_start_q;

  wire        core_busy;
  wire        core_done;
  wire [NBITS-1:0] core_result;
  wire        core_start;
  wire        sar_restart;
  wire        addr_phase;
  wire        wr_ctrl;
  wire        pin_rise;
  wire        diff_now;
  reg         trigger;
  reg  [7:0]  rd_mux;
  reg  [15:0] fmt_word;

  assign addr_phase = hsel && htrans[1] && hready;
  assign wr_ctrl    = wr_pend_q && (wr_idx_q == `SAC_OFS_CTRL);
  assign pin_rise   = pin_sync_q && !pin_prev_q;

  // ground on the negative side selects single-ended mode
  assign diff_now = (neg_mux_sel_q != `SAC_NEG_GND); // [RULE3] [RULE25]

  // two-flop synchronisers for the pin and the comparator
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_meta_q <= 1'b0;
      pin_sync_q <= 1'b0;
      pin_prev_q <= 1'b0;
      cmp_meta_q <= 1'b0;
      cmp_sync_q <= 1'b0;
    end else begin
      pin_meta_q <= external_convert_start;
      pin_sync_q <= pin_meta_q;
      pin_prev_q <= pin_sync_q;
      cmp_meta_q <= comparator_in;
      cmp_sync_q <= cmp_meta_q;
    end
  end

  // sar clock enable: one pulse every divider+1 system clocks
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_cnt_q  <= 5'h00;
      sar_tick_q <= 1'b0;
    end else if (!converter_enable_bit_q) begin
      div_cnt_q  <= 5'h00;
      sar_tick_q <= 1'b0;
    end else if (sar_restart) begin
      div_cnt_q  <= 5'h00; // first step a full period after start
      sar_tick_q <= 1'b0;
    end else if (div_cnt_q >= sar_clock_divider_q) begin // [RULE10]
      div_cnt_q  <= 5'h00;
      sar_tick_q <= 1'b1;
    end else begin
      div_cnt_q  <= div_cnt_q + 5'h01;
      sar_tick_q <= 1'b0;
    end
  end

  // start-source decode
  always @* begin
    case (start_source_select_q) // [RULE11] [RULE23]
      `SAC_SRC_SW:  trigger = sw_start_q; // [RULE12]
      `SAC_SRC_T0:  trigger = timer0_ovf;
      `SAC_SRC_T1:  trigger = timer1_ovf;
      `SAC_SRC_T2:  trigger = timer2_split ? timer2_lo_ovf
                                           : timer2_hi_ovf; // [RULE17]
      `SAC_SRC_T3:  trigger = timer3_split ? timer3_lo_ovf
                                           : timer3_hi_ovf; // [RULE17]
      `SAC_SRC_PIN: trigger = pin_rise; // [RULE18]
      default:      trigger = 1'b0;
    endcase
  end

  // conversion sequencer next state
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        // triggers only act from idle [RULE27]
        if (trigger) begin
          if (track_mode_select_q &&
              start_source_select_q != `SAC_SRC_PIN)
            state_d = ST_TRACK; // [RULE20]
          else
            state_d = ST_CONV; // [RULE21]
        end
      end
      ST_TRACK: begin
        if (sar_tick_q && track_cnt_q == `SAC_TRACK_CLKS - 2'h1)
          state_d = ST_CONV; // [RULE20]
      end
      ST_CONV: begin
        if (core_done)
          state_d = ST_IDLE;
      end
      default: state_d = ST_IDLE;
    endcase
    if (!converter_enable_bit_q)
      state_d = ST_IDLE; // [RULE1]
  end

  assign core_start = (state_q != ST_CONV) && (state_d == ST_CONV);

  // leaving idle realigns the sar clock so the synchronised comparator
  // has settled on the first trial before the first step samples it
  assign sar_restart = (state_q == ST_IDLE) && (state_d != ST_IDLE);

  // sequencer state and tracking period counter
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q     <= ST_IDLE;
      track_cnt_q <= 2'h0;
    end else begin
      state_q <= state_d;
      if (state_q != ST_TRACK)
        track_cnt_q <= 2'h0;
      else if (sar_tick_q)
        track_cnt_q <= track_cnt_q + 2'h1;
    end
  end

  sac_sar_core #(
    .NBITS (NBITS)
  ) u_core (
    .hclk     (hclk),
    .hresetn  (hresetn && converter_enable_bit_q),
    .tick     (sar_tick_q),
    .start    (core_start),
    .cmp_ge   (cmp_sync_q),
    .trial_q  (sar_trial_q),
    .result_q (core_result),
    .busy_q   (core_busy),
    .done_q   (core_done)
  );

  // justify and sign-extend the finished code
  always @* begin
    fmt_word = 16'h0000;
    if (justify_select_q)
      fmt_word = {core_result, 6'h00}; // [RULE24] [RULE5] [RULE8]
    else if (diff_mode_q)
      fmt_word = {{6{core_result[NBITS-1]}}, core_result}; // [RULE6] [RULE7]
    else
      fmt_word = {6'h00, core_result}; // [RULE4] [RULE5]
  end

  // analog-side controls
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      converter_power_q <= 1'b0;
      track_en_q        <= 1'b0;
      diff_mode_q       <= 1'b0;
    end else begin
      converter_power_q <= converter_enable_bit_q; // [RULE1]
      diff_mode_q       <= diff_now; // [RULE3]
      if (!converter_enable_bit_q || low_power_standby)
        track_en_q <= 1'b0; // [RULE22]
      else if (!track_mode_select_q)
        track_en_q <= (state_d == ST_IDLE); // [RULE19]
      else if (start_source_select_q == `SAC_SRC_PIN)
        track_en_q <= (state_d == ST_IDLE) && !pin_sync_q; // [RULE21]
      else
        track_en_q <= (state_d == ST_TRACK); // [RULE20]
    end
  end

  // register read mux
  always @* begin
    case (haddr[7:2])
      `SAC_OFS_CTRL: rd_mux = {converter_enable_bit_q,
                               track_mode_select_q,
                               conversion_done_flag_q,
                               state_q != ST_IDLE, // [RULE13]
                               1'b0,
                               start_source_select_q};
      `SAC_OFS_CFG:  rd_mux = {sar_clock_divider_q, justify_select_q,
                               2'h0};
      `SAC_OFS_POS:  rd_mux = {3'h0, pos_mux_sel_q};
      `SAC_OFS_NEG:  rd_mux = {3'h0, neg_mux_sel_q};
      `SAC_OFS_RES_HI: rd_mux = result_high_byte_q; // [RULE15]
      `SAC_OFS_RES_LO: rd_mux = result_low_byte_q;
      default:       rd_mux = 8'h00;
    endcase
  end

  // bus slave: zero wait states, always okay
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h0000_0000;
      wr_pend_q <= 1'b0;
      wr_idx_q  <= 6'h00;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      wr_pend_q <= addr_phase && hwrite;
      wr_idx_q  <= haddr[7:2];
      if (addr_phase && !hwrite && haddr[31:8] == 24'h000000)
        hrdata <= {24'h000000, rd_mux};
      else if (addr_phase && !hwrite)
        hrdata <= 32'h0000_0000;
    end
  end

  // software registers
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      converter_enable_bit_q <= 1'b0;
      track_mode_select_q    <= 1'b0;
      start_source_select_q  <= 3'h0;
      sar_clock_divider_q    <= RST_CFG[`SAC_CFG_DIV_HI:`SAC_CFG_DIV_LO];
      justify_select_q       <= RST_CFG[`SAC_CFG_LJST];
      pos_mux_sel_q          <= `SAC_RST_POS;
      neg_mux_sel_q          <= `SAC_RST_NEG;
      sw_start_q             <= 1'b0;
    end else begin
      sw_start_q <= 1'b0;
      if (wr_pend_q) begin
        case (wr_idx_q)
          `SAC_OFS_CTRL: begin
            converter_enable_bit_q <= hwdata[`SAC_CTRL_EN];
            track_mode_select_q    <= hwdata[`SAC_CTRL_TM];
            start_source_select_q  <= hwdata[2:0];
            sw_start_q <= hwdata[`SAC_CTRL_BUSY] && hwdata[`SAC_CTRL_EN]
                          && hwdata[2:0] == `SAC_SRC_SW; // [RULE12]
          end
          `SAC_OFS_CFG: begin
            sar_clock_divider_q <= hwdata[`SAC_CFG_DIV_HI:`SAC_CFG_DIV_LO];
            justify_select_q    <= hwdata[`SAC_CFG_LJST]; // [RULE24]
          end
          `SAC_OFS_POS: pos_mux_sel_q <= hwdata[4:0]; // [RULE2]
          `SAC_OFS_NEG: neg_mux_sel_q <= hwdata[4:0]; // [RULE2]
          default: ;
        endcase
      end
    end
  end

  // result load and done flag; hardware set wins over clear
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      conversion_done_flag_q <= 1'b0;
      result_high_byte_q     <= 8'h00;
      result_low_byte_q      <= 8'h00;
      conv_irq_q             <= 1'b0;
    end else begin
      if (core_done && state_q == ST_CONV) begin
        result_high_byte_q     <= fmt_word[15:8]; // [RULE9]
        result_low_byte_q      <= fmt_word[7:0];
        conversion_done_flag_q <= 1'b1; // [RULE14] [RULE26]
      end else if (wr_ctrl) begin
        conversion_done_flag_q <= hwdata[`SAC_CTRL_DONE]; // [RULE26]
      end
      conv_irq_q <= irq_enable && (conversion_done_flag_q ||
                    (core_done && state_q == ST_CONV)); // [RULE14]
    end
  end

endmodule // sac_top

// ### tb/sac_top_properties.sv
`timescale 1ns/10ps

// watches the converter control top from its ports only
module sac_top_checker #(
  parameter NBITS = 10
) (
  input wire             hclk,
  input wire             hresetn,
  input wire             hsel,
  input wire [31:0]      haddr,
  input wire [1:0]       htrans,
  input wire             hwrite,
  input wire             low_power_standby,
  input wire             irq_enable,
  input wire             converter_power_q,
  input wire             track_en_q,
  input wire [4:0]       pos_mux_sel_q,
  input wire [4:0]       neg_mux_sel_q,
  input wire             diff_mode_q,
  input wire             conv_irq_q
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // address phases of writes to the mux selects and the control register
  wire wr_any = hsel & htrans[1] & hwrite;
  wire wr_pos = wr_any & (haddr[7:0] == 8'h08);
  wire wr_neg = wr_any & (haddr[7:0] == 8'h0c);
  wire wr_ctl = wr_any & (haddr[7:0] == 8'h00);

  AST_POS_ROUTE: assert property (
    $changed(pos_mux_sel_q) |-> $past(wr_pos, 2))
    else $error("positive select moved without a write");
  AST_NEG_ROUTE: assert property (
    $changed(neg_mux_sel_q) |-> $past(wr_neg, 2))
    else $error("negative select moved without a write");
  AST_DIFF_MODE: assert property (
    $stable(neg_mux_sel_q)[*3] |-> diff_mode_q == (neg_mux_sel_q != 5'h11))
    else $error("mode flag disagrees with negative select");
  AST_SE_MODE: assert property (
    (neg_mux_sel_q == 5'h11)[*3] |-> !diff_mode_q)
    else $error("ground select not single-ended");
  AST_OFF_NO_TRACK: assert property (
    !converter_power_q[*2] |-> !track_en_q)
    else $error("tracking while converter powered down");
  AST_STANDBY: assert property (
    low_power_standby[*2] |-> !track_en_q)
    else $error("tracking during standby");
  AST_IRQ_GATE: assert property (
    !irq_enable[*2] |-> !conv_irq_q)
    else $error("request raised while disabled");
  AST_IRQ_HOLD: assert property (
    conv_irq_q && irq_enable && !$past(wr_ctl, 2) |=> conv_irq_q)
    else $error("done request dropped without a clear");

  // main scenarios reached
  cover property (diff_mode_q && $rose(conv_irq_q));
  cover property ($rose(track_en_q));
  cover property (low_power_standby && converter_power_q);
endmodule // sac_top_checker

bind sac_top sac_top_checker #(.NBITS(NBITS)) u_chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .low_power_standby(low_power_standby),
  .irq_enable(irq_enable), .converter_power_q(converter_power_q),
  .track_en_q(track_en_q), .pos_mux_sel_q(pos_mux_sel_q),
  .neg_mux_sel_q(neg_mux_sel_q), .diff_mode_q(diff_mode_q),
  .conv_irq_q(conv_irq_q));

// ### tb/tb_sar_adc_conversion_control.sv
`timescale 1ns/10ps
`include "sac_defs.vh"

module tb_sar_adc_conversion_control;
  localparam [7:0] a_ctl = {`SAC_OFS_CTRL, 2'b00};
  localparam [7:0] a_cfg = {`SAC_OFS_CFG, 2'b00};
  localparam [7:0] a_pos = {`SAC_OFS_POS, 2'b00};
  localparam [7:0] a_neg = {`SAC_OFS_NEG, 2'b00};
  localparam [7:0] a_hi  = {`SAC_OFS_RES_HI, 2'b00};
  localparam [7:0] a_lo  = {`SAC_OFS_RES_LO, 2'b00};
  reg         hclk, hresetn, hsel, hwrite, split, pin_lv, standby, irq_en;
  reg  [31:0] haddr, hwdata;
  reg  [1:0]  htrans;
  reg  [6:0]  ev;
  reg  [9:0]  target;
  reg  [7:0]  rd;
  reg  [15:0] res;
  reg  [31:0] ct [0:8];
  reg  [9:0]  tt [0:6];
  wire        hreadyout, hresp, power, track, diff, irq;
  wire [31:0] hrdata;
  wire [4:0]  pos_sel, neg_sel;
  wire [9:0]  trial;
  integer     err_total, num_checks, cyc, t0, t1, i;

  // comparator: analog input at or above the trial code
  wire cmp = (trial <= target);

  sac_top #(.NBITS(10)) dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .timer0_ovf(ev[0]), .timer1_ovf(ev[1]),
    .timer2_lo_ovf(ev[2]), .timer2_hi_ovf(ev[3]), .timer2_split(split),
    .timer3_lo_ovf(ev[4]), .timer3_hi_ovf(ev[5]), .timer3_split(split),
    .external_convert_start(ev[6] | pin_lv), .comparator_in(cmp),
    .low_power_standby(standby), .irq_enable(irq_en),
    .converter_power_q(power), .track_en_q(track),
    .pos_mux_sel_q(pos_sel), .neg_mux_sel_q(neg_sel),
    .diff_mode_q(diff), .sar_trial_q(trial), .conv_irq_q(irq));

  // clock and cycle count
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  always @(posedge hclk) cyc <= cyc + 1;

  task complete_run;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task chk(input string nm, input [15:0] seen, input [15:0] exp);
    num_checks = num_checks + 1;
    if (seen !== exp) begin
      err_total = err_total + 1;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one single transfer: address phase, then data phase
  task bus(input wr, input [7:0] a, input [7:0] d);
    hsel <= 1'b1; haddr <= {24'h0, a}; htrans <= 2'h2; hwrite <= wr;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= {24'h0, d};
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata[7:0];
    chk("response", {15'h0, hresp}, 16'h0000);
  endtask

  task rdchk(input [7:0] a, input [7:0] e);
    bus(1'b0, a, 8'h00);
    chk("register", {8'h00, rd}, {8'h00, e});
  endtask

  task wait_done;
    integer k;
    k = 0;
    rd = 8'h00;
    while (rd[5] !== 1'b1 && k < 200) begin // poll the done flag
      bus(1'b0, a_ctl, 8'h00);
      k = k + 1;
    end
    chk("done_wait", {15'h0, k < 200}, 16'h0001);
  endtask

  task pulse(input [2:0] g);
    ev <= 7'h01 << g;
    @(posedge hclk);
    ev <= 7'h00;
    repeat (5) @(posedge hclk);
    bus(1'b0, a_ctl, 8'h00);
  endtask

  // software conversion of one table row {neg, justify, code, result}
  task conv_row(input [31:0] e);
    bus(1'b1, a_neg, {3'h0, e[31:27]});
    bus(1'b1, a_cfg, {5'h03, e[26], 2'b00});
    target <= e[25:16];
    bus(1'b1, a_ctl, 8'h90);
    repeat (3) @(posedge hclk);
    bus(1'b0, a_ctl, 8'h00);
    chk("busy", {15'h0, rd[4]}, 16'h0001);
    chk("track_conv", {15'h0, track}, 16'h0000);
    wait_done;
    chk("flags", {14'h0, rd[5:4]}, 16'h0002);
    chk("irq_masked", {15'h0, irq}, 16'h0000);
    bus(1'b0, a_hi, 8'h00);
    res[15:8] = rd;
    bus(1'b0, a_lo, 8'h00);
    res[7:0] = rd;
    chk("result", res, e[15:0]);
    chk("mode", {15'h0, diff}, {15'h0, e[31:27] != 5'h11});
    chk("neg_route", {11'h0, neg_sel}, {11'h0, e[31:27]});
    rdchk(a_ctl, 8'ha0);
    bus(1'b1, a_ctl, 8'h80);
    rdchk(a_ctl, 8'h80);
  endtask

  // start a conversion, optionally retrigger it, time it to the request
  task meas(input [7:0] c, input rt, output integer n);
    integer s;
    integer k;
    bus(1'b1, a_ctl, c);
    s = cyc;
    k = 0;
    if (rt) begin
      repeat (8) @(posedge hclk);
      bus(1'b1, a_ctl, c);
    end
    while (irq !== 1'b1 && k < 300) begin
      @(negedge hclk); // look at the request once it has settled
      k = k + 1;
    end
    chk("irq_wait", {15'h0, k < 300}, 16'h0001);
    n = cyc - s;
    repeat (4) @(posedge hclk);
    bus(1'b1, a_ctl, 8'h80);
    repeat (3) @(posedge hclk);
    chk("irq_clear", {15'h0, irq}, 16'h0000);
  endtask

  // watchdog far beyond the expected run length
  initial begin
    #200000;
    err_total = err_total + 1;
    complete_run;
  end

  initial begin
    hresetn = 1'b0; hsel = 1'b0; hwrite = 1'b0; haddr = 32'h0;
    hwdata = 32'h0; htrans = 2'h0; ev = 7'h00; split = 1'b0;
    pin_lv = 1'b0; standby = 1'b0; irq_en = 1'b0; target = 10'h000;
    err_total = 0; num_checks = 0; cyc = 0;
    ct[0] = {5'h11, 1'b0, 10'h3ff, 16'h03ff};
    ct[1] = {5'h11, 1'b1, 10'h3ff, 16'hffc0};
    ct[2] = {5'h11, 1'b0, 10'h100, 16'h0100};
    ct[3] = {5'h10, 1'b0, 10'h200, 16'hfe00};
    ct[4] = {5'h10, 1'b1, 10'h200, 16'h8000};
    ct[5] = {5'h10, 1'b0, 10'h300, 16'hff00};
    ct[6] = {5'h10, 1'b1, 10'h300, 16'hc000};
    ct[7] = {5'h00, 1'b1, 10'h1ff, 16'h7fc0};
    ct[8] = {5'h1f, 1'b0, 10'h1ff, 16'h01ff};
    // {source, good event, wrong event, timer 8-bit mode}
    tt[0] = {`SAC_SRC_T0, 3'h0, 3'h1, 1'b0};
    tt[1] = {`SAC_SRC_T1, 3'h1, 3'h0, 1'b0};
    tt[2] = {`SAC_SRC_T2, 3'h2, 3'h3, 1'b1};
    tt[3] = {`SAC_SRC_T2, 3'h3, 3'h2, 1'b0};
    tt[4] = {`SAC_SRC_T3, 3'h4, 3'h5, 1'b1};
    tt[5] = {`SAC_SRC_T3, 3'h5, 3'h4, 1'b0};
    tt[6] = {`SAC_SRC_PIN, 3'h6, 3'h0, 1'b0};
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdchk(a_ctl, 8'h00);
    rdchk(a_cfg, 8'hf8);
    rdchk(a_pos, 8'h1f);
    rdchk(a_neg, 8'h1f);
    rdchk(8'h18, 8'h00);
    chk("mode_reset", {15'h0, diff}, 16'h0001);
    bus(1'b1, a_ctl, 8'h10);
    repeat (4) @(posedge hclk);
    rdchk(a_ctl, 8'h00);
    chk("power_off", {14'h0, power, track}, 16'h0000);
    bus(1'b1, a_pos, 8'he5);
    rdchk(a_pos, 8'h05);
    chk("pos_route", {11'h0, pos_sel}, 16'h0005);
    bus(1'b1, a_ctl, 8'h80);
    repeat (3) @(posedge hclk);
    chk("track_idle", {14'h0, power, track}, 16'h0003);
    standby <= 1'b1;
    repeat (3) @(posedge hclk);
    chk("standby", {15'h0, track}, 16'h0000);
    standby <= 1'b0;
    bus(1'b1, a_ctl, 8'h96);
    repeat (4) @(posedge hclk);
    rdchk(a_ctl, 8'h86);
    for (i = 0; i < 9; i = i + 1) conv_row(ct[i]);
    for (i = 0; i < 7; i = i + 1) begin
      split <= tt[i][0];
      bus(1'b1, a_ctl, {5'h10, tt[i][9:7]});
      pulse(tt[i][3:1]);
      chk("wrong_event", {15'h0, rd[4]}, 16'h0000);
      pulse(tt[i][6:4]);
      chk("trigger", {15'h0, rd[4]}, 16'h0001);
      wait_done;
      chk("trig_done", {15'h0, rd[5]}, 16'h0001);
      bus(1'b1, a_ctl, 8'h80);
    end
    irq_en <= 1'b1;
    meas(8'h90, 1'b0, t0);
    chk("conv_time", {15'h0, t0 >= 40 && t0 <= 52}, 16'h0001);
    meas(8'h90, 1'b1, t1);
    chk("retrigger", {15'h0, t1 - t0 <= 4 && t0 - t1 <= 4}, 16'h0001);
    meas(8'hd0, 1'b0, t1);
    chk("lp_track", {15'h0, t1 - t0 >= 9 && t1 - t0 <= 15}, 16'h0001);
    bus(1'b1, a_cfg, 8'h38);
    meas(8'h90, 1'b0, t1);
    chk("divider", {15'h0, t1 >= 80 && t1 <= 96}, 16'h0001);
    bus(1'b1, a_ctl, 8'hc4);
    repeat (4) @(posedge hclk);
    chk("pin_low", {15'h0, track}, 16'h0001);
    pin_lv <= 1'b1;
    repeat (5) @(posedge hclk);
    chk("pin_conv", {15'h0, track}, 16'h0000);
    wait_done;
    chk("pin_done", {15'h0, rd[5]}, 16'h0001);
    chk("pin_high", {15'h0, track}, 16'h0000);
    complete_run;
  end
endmodule // tb_sar_adc_conversion_control
